// *** pkg/wtu_params.svh ***
// constants for the watch-trace id words and sleep counter block
// assumes inclusion by bare name from design and testbench files
`ifndef WTU_PARAMS_SVH
`define WTU_PARAMS_SVH

// register byte addresses
`define WTU_ADDR_SLEEP 32'he0001010
`define WTU_ADDR_PID4 32'he0001fd0
`define WTU_ADDR_PID5 32'he0001fd4
`define WTU_ADDR_PID6 32'he0001fd8
`define WTU_ADDR_PID7 32'he0001fdc
`define WTU_ADDR_PID1 32'he0001fe4
`define WTU_ADDR_PID2 32'he0001fe8
`define WTU_ADDR_PID3 32'he0001fec

// field positions
`define WTU_SLEEP_MSB 7
`define WTU_HI_NIB_LSB 4
`define WTU_JEDEC_BIT 3

// id field values, arbitrary neutral choices
`define WTU_PART_HI 4'h0
`define WTU_DES_HI 3'h0
`define WTU_DES_CONT 4'h0
`define WTU_REVISION 4'h0
`define WTU_MINOR_REV 4'h0
`define WTU_CUST_MOD 4'h0
`define WTU_SIZE_4K 4'h0

// reset value chosen for the counter although software must not rely on it
`define WTU_SLEEP_RST 8'h00

`endif

// *** pkg/wtu_pkg.sv ***
// types shared by the watch-trace id and sleep counter block
// assumes wtu_params.svh is on the include path
package wtu_pkg;

    // register bus request from the core
    typedef struct packed {
        logic        sel;
        logic        wr;
        logic        priv;
        logic        dbg;
        logic [31:0] addr;
        logic [31:0] wdata;
    } wtu_req_s;

    // processor activity seen by the counter
    typedef struct packed {
        logic instr_exec;
        logic lsu_busy;
        logic exc_busy;
        logic power_save;
        logic deep_sleep_select;
        logic nonsecure;
        logic sec_nid_allowed;
        logic nid_allowed;
    } wtu_core_s;

    // counter engine states
    typedef enum logic [1:0] {
        WTU_IDLE = 2'b01,
        WTU_RUN  = 2'b10
    } wtu_state_e;

endpackage

// *** hdl/wtu_id_rom.sv ***
// peripheral identification word lookup
// assumes a registered caller; read data leave this module from a flop
`timescale 1ns/1ps
`default_nettype none
`include "wtu_params.svh"

module wtu_id_rom
    import wtu_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // lookup
    input wire logic [31:0] addr,
    input wire logic id_present,
    output logic [31:0] id_word_q
);

    logic [31:0] id_word_d; // selected word before the flop

    // reserved bits 31:8 stay zero in every word
    always_comb begin
        id_word_d = 32'h0;
        if (id_present) begin
            unique case (addr)
                `WTU_ADDR_PID1: id_word_d[3:0] = `WTU_PART_HI;
                `WTU_ADDR_PID2: id_word_d[7:0] = {`WTU_REVISION, 1'b1,
                    `WTU_DES_HI};
                `WTU_ADDR_PID3: id_word_d[7:0] = {`WTU_MINOR_REV,
                    `WTU_CUST_MOD};
                `WTU_ADDR_PID4: id_word_d[7:0] = {`WTU_SIZE_4K,
                    `WTU_DES_CONT};
                default: id_word_d = 32'h0; // words 5 to 7 are all zero
            endcase
        end
    end

    // registered read data
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            id_word_q <= 32'h0;
        end else begin
            id_word_q <= id_word_d;
        end
    end

endmodule
`default_nettype wire

// *** hdl/wtu_sleep_ctr.sv ***
// eight bit sleep cycle counter with overflow pulse
// assumes qualifying conditions are synchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "wtu_params.svh"

module wtu_sleep_ctr
    import wtu_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // control
    input wire logic count_en,
    input wire logic clear,
    input wire logic load,
    input wire logic [7:0] load_val,
    // state
    output logic [7:0] count_q,
    output logic overflow_q
);

    logic [7:0] count_d; // next count
    wire wrap = count_en && (count_q == 8'hff); // all ones about to roll

    // clear wins, then a software load, then counting
    always_comb begin
        count_d = count_q;
        if (clear) begin
            count_d = 8'h00;
        end else if (load) begin
            count_d = load_val;
        end else if (count_en) begin
            count_d = count_q + 8'h01;
        end
    end

    // counter and overflow event flops
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_q <= `WTU_SLEEP_RST;
            overflow_q <= 1'b0;
        end else begin
            count_q <= count_d;
            overflow_q <= wrap && !clear && !load;
        end
    end

    a_wrap_to_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (count_en && !clear && !load && count_q == 8'hff)
        |=> (count_q == 8'h00 && overflow_q))
        else $error("counter did not wrap with overflow");

    a_hold_when_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!count_en && !clear && !load) |=> $stable(count_q))
        else $error("counter moved without enable");

endmodule
`default_nettype wire

// *** hdl/wtu_regs.sv ***
// register bank: id words 1 to 7 and the sleep cycle counter
// assumes one request per cycle, word accesses only, inputs synchronous

`timescale 1ns/1ps
`default_nettype none
`include "wtu_params.svh"

module wtu_regs
    import wtu_pkg::*;
#(
    parameter bit MAIN_EXT = 1'b1,
    parameter bit ID_IMPL = 1'b1,
    parameter bit ID_DEBUG_ONLY = 1'b0,
    parameter bit COUNT_IN_DEEP = 1'b1
)(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register request
    input wire wtu_req_s req,
    output logic ack_q,
    output logic bus_fault_a_q,
    output logic [31:0] rdata_q,
    // control bits held elsewhere in the trace unit
    input wire logic sleep_event_enable,
    input wire logic sleep_event_enable_wr,
    input wire logic global_trace_enable,
    input wire logic no_profile_counters,
    // processor activity
    input wire wtu_core_s core,
    // trace output
    output logic event_packet_q
);

    // decode; every register has one copy regardless of security
    function automatic logic is_id(input logic [31:0] a);
        return (a[31:6] == `WTU_ADDR_PID4 >> 6) && (a[5:4] != 2'b00) ||
            (a == `WTU_ADDR_PID4) || (a == `WTU_ADDR_PID5) ||
            (a == `WTU_ADDR_PID6) || (a == `WTU_ADDR_PID7);
    endfunction

    wire hit_sleep = req.addr == `WTU_ADDR_SLEEP;
    wire hit_id = (req.addr == `WTU_ADDR_PID1) ||
        (req.addr == `WTU_ADDR_PID2) || (req.addr == `WTU_ADDR_PID3) ||
        is_id(req.addr) && (req.addr[3:0] == 4'h0 ||
        req.addr[3:0] == 4'h4 || req.addr[3:0] == 4'h8 ||
        req.addr[3:0] == 4'hc) && req.addr[11:8] == 4'hf &&
        (req.addr[7:4] == 4'hd);
    wire fault = req.sel && !req.priv && !req.dbg;
    wire take = req.sel && !fault;

    // without main extension the id words may be hidden from software
    wire id_visible = ID_IMPL && (MAIN_EXT || !ID_DEBUG_ONLY ||
        req.dbg);
    // counter exists with main extension and profiling counters
    wire ctr_present = MAIN_EXT && !no_profile_counters;

    // counting qualifiers
    wire enabled = sleep_event_enable && global_trace_enable;
    wire idle = !core.instr_exec && !core.lsu_busy &&
        !core.exc_busy;
    wire sleeping = core.power_save &&
        (COUNT_IN_DEEP || !core.deep_sleep_select);
    wire observe = core.sec_nid_allowed ||
        (core.nonsecure && core.nid_allowed);
    wire count_en = ctr_present && enabled && idle && sleeping && observe;

    // enable written with one while the enable bit was clear and global trace enable was set
    wire restart = sleep_event_enable_wr && !enabled &&
        global_trace_enable;
    wire sw_load = take && req.wr && hit_sleep && ctr_present;

    logic [7:0] count_q; // live count
    logic [31:0] id_word_q; // registered id lookup
    logic ctr_rd_q; // last read was the counter
    logic [7:0] ctr_snap_q; // counter value at read time
    wtu_state_e state_q; // engine state
    wtu_state_e state_d;

    // id lookup, registered
    wtu_id_rom u_rom (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .addr(req.addr),
        .id_present(id_visible && hit_id),
        .id_word_q(id_word_q)
    );

    // counter engine
    wtu_sleep_ctr u_ctr (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .count_en(count_en),
        .clear(restart),
        .load(sw_load),
        .load_val(req.wdata[`WTU_SLEEP_MSB:0]),
        .count_q(count_q),
        .overflow_q(event_packet_q)
    );

    // state follows whether counting is armed
    always_comb begin
        unique case (state_q)
            WTU_IDLE: state_d = enabled ? WTU_RUN : WTU_IDLE;
            WTU_RUN: state_d = enabled ? WTU_RUN : WTU_IDLE;
            default: state_d = WTU_IDLE;
        endcase
    end

    // bus answer one cycle after the request
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            bus_fault_a_q <= 1'b0;
            ctr_rd_q <= 1'b0;
            ctr_snap_q <= 8'h00;
            state_q <= WTU_IDLE;
        end else begin
            ack_q <= take;
            bus_fault_a_q <= fault;
            ctr_rd_q <= take && !req.wr && hit_sleep && ctr_present;
            ctr_snap_q <= count_q;
            state_q <= state_d;
        end
    end

    // read data mux; unmapped and reserved read zero
    always_comb begin
        rdata_q = 32'h0;
        if (ctr_rd_q) begin
            rdata_q = {24'h0, ctr_snap_q};
        end else if (ack_q) begin
            rdata_q = id_word_q;
        end
    end

    a_fault_unpriv: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (req.sel && !req.priv && !req.dbg) |=> (bus_fault_a_q && !ack_q))
        else $error("unprivileged access not faulted");

    a_no_count_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (core.instr_exec || core.lsu_busy || core.exc_busy) |-> !count_en)
        else $error("counting while core busy");

    a_awake_no_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!core.power_save && !restart && !sw_load) |=> $stable(count_q))
        else $error("counter moved while awake");

    a_debug_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!core.sec_nid_allowed && !(core.nonsecure && core.nid_allowed))
        |-> !count_en) else $error("counting while debug barred");

    a_enable_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!sleep_event_enable || !global_trace_enable) |-> !count_en)
        else $error("counting while disabled");

    a_restart_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        restart |=> count_q == 8'h00) else $error("restart not clear");

    a_absent_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        no_profile_counters |-> !count_en)
        else $error("counting without profiling counters");

    a_count_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (count_en && !restart && !sw_load) |=>
        count_q == $past(count_q) + 8'h01) else $error("bad step");

endmodule
`default_nettype wire

// *** testbench/wtu_host_model.sv ***
// host model: privileged software or a debugger on the register bus
// assumes the bank samples a request on each rising edge of ref_clk
`timescale 1ns/1ps
`default_nettype none

module wtu_host_model
    import wtu_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // request towards the bank
    output var wtu_req_s req,
    // answer from the bank
    input wire logic ack_q,
    input wire logic bus_fault_a_q,
    input wire logic [31:0] rdata_q
);
    // deselected from time zero
    initial req = '0;

    // one whole word access, answer taken in the cycle after the request
    // released fields show inverted junk so stale values never look valid
    task automatic access(input logic wr, input logic priv,
        input logic dbg, input logic [31:0] addr, input logic [31:0] wd,
        output logic [31:0] rd, output logic [1:0] resp);
        @(negedge ref_clk);
        req <= {1'b1, wr, priv, dbg, addr, wd}; // full word only
        @(negedge ref_clk);
        rd = rdata_q;
        resp = {bus_fault_a_q, ack_q};
        req <= {1'b0, ~wr, ~priv, ~dbg, ~addr, ~wd};
    endtask
endmodule

`default_nettype wire

// *** testbench/trace_id_regs_sleep_counter_test.sv ***
// self-checking bench for the id words and the sleep cycle counter
// assumes all register traffic goes through the host model
`timescale 1ns/1ps
`default_nettype none
`include "wtu_params.svh"

module trace_id_regs_sleep_counter_test
    import wtu_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    wtu_req_s req;
    wtu_core_s core = '0; // processor activity levels
    logic ev = 1'b0; // counter event enable
    logic ev_wr = 1'b0; // enable written with one
    logic gte = 1'b0; // global trace enable
    logic nopf = 1'b0; // no profiling counters
    logic ack_q, flt_q, pkt_q;
    logic [31:0] rdata_q, d;
    int fails = 0, samples_checked = 0, pkts = 0, cycles = 0;

    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;

    wtu_regs i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .req(req),
        .ack_q(ack_q), .bus_fault_a_q(flt_q), .rdata_q(rdata_q),
        .sleep_event_enable(ev), .sleep_event_enable_wr(ev_wr),
        .global_trace_enable(gte), .no_profile_counters(nopf),
        .core(core), .event_packet_q(pkt_q));

    wtu_host_model i_host (.ref_clk(ref_clk), .req(req), .ack_q(ack_q),
        .bus_fault_a_q(flt_q), .rdata_q(rdata_q));

    // count overflow packets; a run far past its length is a hang
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (pkt_q === 1'b1)
            pkts <= pkts + 1;
        if (cycles == 5000) begin
            fails++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] got,
        input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one access with its expected response {fault, ack}
    task automatic acc(input logic wr, input logic priv, input logic dbg,
        input logic [31:0] a, input logic [31:0] wd,
        input logic [1:0] er, output logic [31:0] rd);
        logic [1:0] r;
        i_host.access(wr, priv, dbg, a, wd, rd, r);
        check("response", {30'h0, r}, {30'h0, er});
    endtask

    // hold {enable, trace enable, activity} for n edges, then go busy-free
    task automatic run(input logic [9:0] v, input int n);
        @(negedge ref_clk);
        {ev, gte, core} = v;
        repeat (n) @(negedge ref_clk);
        core = '0;
    endtask

    // id words, their read-only nature, debugger path and a hole
    task automatic t_ids();
        logic [31:0] a [7] = '{`WTU_ADDR_PID1, `WTU_ADDR_PID2,
            `WTU_ADDR_PID3, `WTU_ADDR_PID4, `WTU_ADDR_PID5,
            `WTU_ADDR_PID6, `WTU_ADDR_PID7};
        logic [31:0] e [7] = '{{28'h0, `WTU_PART_HI},
            {24'h0, `WTU_REVISION, 1'b1, `WTU_DES_HI},
            {24'h0, `WTU_MINOR_REV, `WTU_CUST_MOD},
            {24'h0, 4'h0, `WTU_DES_CONT}, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 7; i++) begin
            acc(1'b1, 1'b1, 1'b0, a[i], 32'hffffffff, 2'b01, d);
            acc(1'b0, 1'b1, 1'b0, a[i], 32'h0, 2'b01, d);
            check("id word", d, e[i]);
        end
        acc(1'b0, 1'b0, 1'b1, `WTU_ADDR_PID2, 32'h0, 2'b01, d);
        check("debugger id2", d, e[1]);
        acc(1'b0, 1'b1, 1'b0, 32'he0001ff0, 32'h0, 2'b01, d);
        check("hole", d, 32'h0);
    endtask

    // unprivileged software is refused and changes nothing
    task automatic t_fault();
        acc(1'b1, 1'b1, 1'b0, `WTU_ADDR_SLEEP, 32'h33, 2'b01, d);
        acc(1'b1, 1'b0, 1'b0, `WTU_ADDR_SLEEP, 32'h55, 2'b10, d);
        acc(1'b0, 1'b0, 1'b0, `WTU_ADDR_SLEEP, 32'h0, 2'b10, d);
        check("fault data", d, 32'h0);
        acc(1'b0, 1'b1, 1'b0, `WTU_ADDR_SLEEP, 32'h0, 2'b01, d);
        check("after fault", d, 32'h33);
    endtask

    // every qualifier in turn; only the listed cases may count
    task automatic t_table();
        logic [9:0] t [12] = '{10'h312, 10'h392, 10'h352, 10'h332,
            10'h302, 10'h112, 10'h212, 10'h310, 10'h314, 10'h315,
            10'h311, 10'h31a};
        logic [11:0] yes = 12'b1010_0000_0001;
        logic [7:0] x = 8'h10;
        acc(1'b1, 1'b1, 1'b0, `WTU_ADDR_SLEEP, {24'h0, x}, 2'b01, d);
        for (int i = 0; i < 12; i++) begin
            run(t[i], 3);
            if (yes[i])
                x = x + 8'h3;
            acc(1'b0, 1'b1, 1'b0, `WTU_ADDR_SLEEP, 32'h0, 2'b01, d);
            check("count", d, {24'h0, x});
        end
    endtask

    // wrap past all ones keeps counting and emits one packet
    task automatic t_wrap();
        int p;
        acc(1'b1, 1'b1, 1'b0, `WTU_ADDR_SLEEP, 32'hfd, 2'b01, d);
        p = pkts;
        run(10'h312, 5);
        acc(1'b0, 1'b1, 1'b0, `WTU_ADDR_SLEEP, 32'h0, 2'b01, d);
        check("wrap", d, 32'h02);
        check("packets", pkts - p, 32'h1);
    endtask

    // enable write restarts only while counting is off; the first pass
    // writes while already enabled and must keep the value
    task automatic t_restart();
        acc(1'b1, 1'b1, 1'b0, `WTU_ADDR_SLEEP, 32'h44, 2'b01, d);
        for (int i = 0; i < 2; i++) begin
            @(negedge ref_clk);
            {ev, gte, ev_wr} = {!i[0], 2'b11};
            @(negedge ref_clk);
            {ev, ev_wr} = 2'b10;
            acc(1'b0, 1'b1, 1'b0, `WTU_ADDR_SLEEP, 32'h0, 2'b01, d);
            check("restart", d, i[0] ? 32'h0 : 32'h44);
        end
    endtask

    // without profiling counters the counter reads zero, writes dropped
    task automatic t_absent();
        acc(1'b1, 1'b1, 1'b0, `WTU_ADDR_SLEEP, 32'h21, 2'b01, d);
        @(negedge ref_clk);
        nopf = 1'b1;
        acc(1'b1, 1'b1, 1'b0, `WTU_ADDR_SLEEP, 32'h77, 2'b01, d);
        acc(1'b0, 1'b1, 1'b0, `WTU_ADDR_SLEEP, 32'h0, 2'b01, d);
        check("absent", d, 32'h0);
        nopf = 1'b0;
        acc(1'b0, 1'b1, 1'b0, `WTU_ADDR_SLEEP, 32'h0, 2'b01, d);
        check("kept", d, 32'h21);
    endtask

    // reset, then each scenario in turn
    initial begin
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        t_ids();
        t_fault();
        t_table();
        t_wrap();
        t_restart();
        t_absent();
        summarize();
    end
endmodule

`default_nettype wire
